// ===== shared/fpu_exc_defines.svh
// fpu exception and trap constants: offsets, field positions, results
// assumes inclusion by bare name from design, checker and testbench
`ifndef FPU_EXC_DEFINES_SVH
`define FPU_EXC_DEFINES_SVH
// psw flag positions
`define PSW_ANY_BIT 31
`define PSW_INV_BIT 30
`define PSW_OVF_BIT 29
`define PSW_DVZ_BIT 28
`define PSW_UNF_BIT 27
`define PSW_INX_BIT 26
`define PSW_RND_LSB 24
// apb register byte offsets
`define OFS_TRAP_CTRL 12'h000
`define OFS_TRAP_PC 12'h004
`define OFS_TRAP_OPC 12'h008
`define OFS_TRAP_SRC1 12'h010
`define OFS_TRAP_SRC2 12'h014
`define OFS_TRAP_SRC3 12'h018
`define OFS_PSW_FLAGS 12'h030
`define OFS_FLAG_UPDATE 12'h034
// trap control fields
`define CTL_CAP_FLAG_LSB 26
`define CTL_EN_LSB 18
`define CTL_CAP_RND_LSB 8
`define CTL_CLEAR_BIT 1
`define CTL_VALID_BIT 0
// trap identity
`define TRAP_CLASS 3'h4
`define TRAP_IDENT 8'h04
// defined results
`define QNAN_OPERAND 32'h7FC00000
`define QNAN_INF_CANCEL 32'h7FC00001
`define QNAN_ZERO_INF 32'h7FC00002
`define QNAN_SEED_NEG 32'h7FC00004
`define QNAN_DIV_INV 32'h7FC00008
`define POS_INF 32'h7F800000
`define NEG_INF 32'hFF800000
`define MAX_FIN_MAG 31'h7F7FFFFF
`define RESET_WORD 32'h00000000
`endif

// ===== shared/fpu_exc_pkg.sv
// types shared by the fpu exception unit
// assumes the defines header on the include path
package fpu_exc_pkg;
    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_PLUS = 2'h1,
        RND_MINUS = 2'h2,
        RND_ZERO = 2'h3
    } rounding_select_e;
    typedef enum logic [7:0] {
        OP_NONE = 8'h01,
        OP_ADD = 8'h02,
        OP_SUB = 8'h04,
        OP_MUL = 8'h08,
        OP_MADD = 8'h10,
        OP_MSUB = 8'h20,
        OP_DIV = 8'h40,
        OP_OTHER = 8'h80
    } fpu_op_e;
    // one completing instruction from the pipeline
    typedef struct packed {
        logic valid;
        logic flag_update_op;
        logic may_except;
        logic [4:0] flags;
        logic [4:0] update_flags;
        logic [1:0] rounding_select;
        logic [31:0] pc;
        logic [8:0] opcode;
        logic [3:0] dreg;
        logic [31:0] src1;
        logic [31:0] src2;
        logic [31:0] src3;
    } fpu_retire_s;
    // operand classification for special results
    typedef struct packed {
        logic [7:0] op;
        logic recip_sqrt_seed_op;
        logic any_nan;
        logic snan;
        logic inf_a;
        logic inf_b;
        logic inf_c;
        logic zero_a;
        logic zero_b;
        logic sign_a;
        logic sign_b;
        logic sign_c;
        logic prod_inf;
        logic prod_sign;
        logic overflow;
        logic underflow;
        logic inexact;
        logic conv_range;
        logic res_sign;
        logic [31:0] rounded;
    } fpu_classify_s;
endpackage

// ===== design/fpu_exception_trap_logic.sv
// fpu exception flags, special results and asynchronous trap capture
// assumes the pipeline presents classification per op and a retire strobe
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fpu_exc_defines.svh"
module fpu_exception_trap_logic
    import fpu_exc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire fpu_classify_s CLASSIFY,
    output logic [31:0] RESULT,
    output logic [4:0] OP_FLAGS,
    input wire fpu_retire_s RETIRE,
    input wire logic ALU_FLAG_WE,
    input wire logic [4:0] ALU_FLAGS,
    output logic [5:0] PSW_FLAGS,
    output logic [1:0] ROUNDING_SELECT,
    output logic TRAP_REQ,
    output logic [2:0] TRAP_CLASS,
    output logic [7:0] TRAP_IDENT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    // ************************************************************
    // special results and per-op flags
    // ************************************************************
    logic f_inv;
    logic f_ovf;
    logic f_dvz;
    logic f_unf;
    logic f_inx;
    logic [31:0] next_result;
    logic is_mac;
    logic cancel;
    logic zero_inf;
    logic div_inv;
    logic div_zero;
    logic seed_neg;
    logic seed_negzero;
    logic inf_div_zero;
    logic [31:0] ovf_value;
    assign is_mac = (CLASSIFY.op == OP_MADD) || (CLASSIFY.op == OP_MSUB);
    always_comb begin
        cancel = 1'b0;
        case (CLASSIFY.op)
            OP_ADD: cancel = CLASSIFY.inf_a && CLASSIFY.inf_b
                && (CLASSIFY.sign_a != CLASSIFY.sign_b);
            OP_SUB: cancel = CLASSIFY.inf_a && CLASSIFY.inf_b
                && (CLASSIFY.sign_a == CLASSIFY.sign_b);
            OP_MADD: cancel = CLASSIFY.prod_inf && CLASSIFY.inf_c
                && (CLASSIFY.prod_sign != CLASSIFY.sign_c);
            OP_MSUB: cancel = CLASSIFY.prod_inf && CLASSIFY.inf_c
                && (CLASSIFY.prod_sign == CLASSIFY.sign_c);
            default: cancel = 1'b0;
        endcase
    end
    assign zero_inf = ((CLASSIFY.op == OP_MUL) || is_mac)
        && ((CLASSIFY.zero_a && CLASSIFY.inf_b) || (CLASSIFY.inf_a && CLASSIFY.zero_b));
    assign div_inv = (CLASSIFY.op == OP_DIV) && ((CLASSIFY.zero_a && CLASSIFY.zero_b)
        || (CLASSIFY.inf_a && CLASSIFY.inf_b));
    assign div_zero = (CLASSIFY.op == OP_DIV) && CLASSIFY.zero_b
        && !CLASSIFY.zero_a && !CLASSIFY.inf_a && !CLASSIFY.any_nan;
    assign inf_div_zero = (CLASSIFY.op == OP_DIV) && CLASSIFY.inf_a && CLASSIFY.zero_b;
    // negative zero is not negative: seed of it is minus infinity
    assign seed_negzero = CLASSIFY.recip_sqrt_seed_op && CLASSIFY.zero_a && CLASSIFY.sign_a;
    assign seed_neg = CLASSIFY.recip_sqrt_seed_op && CLASSIFY.sign_a
        && !CLASSIFY.zero_a && !CLASSIFY.any_nan;
    always_comb begin
        case (rounding_select_e'(ROUNDING_SELECT))
            RND_NEAREST: ovf_value = CLASSIFY.res_sign ? `NEG_INF : `POS_INF;
            RND_ZERO: ovf_value = {CLASSIFY.res_sign, `MAX_FIN_MAG};
            RND_MINUS: ovf_value = CLASSIFY.res_sign ? `NEG_INF : {1'b0, `MAX_FIN_MAG};
            RND_PLUS: ovf_value = CLASSIFY.res_sign ? {1'b1, `MAX_FIN_MAG} : `POS_INF;
            default: ovf_value = `POS_INF;
        endcase
    end
    // priority keeps the four main flags mutually exclusive
    always_comb begin
        f_inv = 1'b0;
        f_ovf = 1'b0;
        f_dvz = 1'b0;
        f_unf = 1'b0;
        f_inx = 1'b0;
        next_result = CLASSIFY.rounded;
        if (CLASSIFY.any_nan) begin
            next_result = `QNAN_OPERAND;
            f_inv = CLASSIFY.snan;
        end else if (cancel) begin
            next_result = `QNAN_INF_CANCEL;
            f_inv = 1'b1;
        end else if (zero_inf) begin
            next_result = `QNAN_ZERO_INF;
            f_inv = 1'b1;
        end else if (seed_neg) begin
            next_result = `QNAN_SEED_NEG;
            f_inv = 1'b1;
        end else if (seed_negzero) begin
            next_result = `NEG_INF;
        end else if (div_inv) begin
            next_result = `QNAN_DIV_INV;
            f_inv = 1'b1;
        end else if (CLASSIFY.conv_range) begin
            f_inv = 1'b1;
        end else if (inf_div_zero || CLASSIFY.inf_a || CLASSIFY.inf_b || CLASSIFY.inf_c) begin
            next_result = CLASSIFY.res_sign ? `NEG_INF : `POS_INF;
        end else if (div_zero) begin
            next_result = CLASSIFY.res_sign ? `NEG_INF : `POS_INF;
            f_dvz = 1'b1;
        end else if (CLASSIFY.overflow) begin
            next_result = ovf_value;
            f_ovf = 1'b1;
            f_inx = 1'b1;
        end else if (CLASSIFY.underflow) begin
            f_unf = 1'b1;
            f_inx = 1'b1;
        end else begin
            f_inx = CLASSIFY.inexact;
        end
    end
    logic [4:0] next_op_flags;
    assign next_op_flags = {f_inv, f_ovf, f_dvz, f_unf, f_inx};
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RESULT <= `RESET_WORD;
            OP_FLAGS <= 5'h00;
        end else begin
            RESULT <= next_result;
            OP_FLAGS <= next_op_flags;
        end
    end
    // ************************************************************
    // status word flags
    // ************************************************************
    logic [4:0] sticky;
    logic any_exc;
    logic [1:0] rnd;
    logic apb_wr;
    logic wr_ctrl;
    logic wr_psw;
    logic wr_rnd;
    logic [31:0] enables;
    assign apb_wr = PSEL && PENABLE && PWRITE;
    // one strobe per writable word; unmapped writes fall out here
    always_comb begin
        wr_ctrl = 1'b0;
        wr_psw = 1'b0;
        wr_rnd = 1'b0;
        if (apb_wr) begin
            case (PADDR)
                `OFS_TRAP_CTRL: wr_ctrl = 1'b1;
                `OFS_PSW_FLAGS: wr_psw = 1'b1;
                `OFS_FLAG_UPDATE: wr_rnd = 1'b1;
                default: wr_ctrl = 1'b0;
            endcase
        end
    end
    // alu shares these bits, so its write beats everything
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sticky <= 5'h00;
        end else if (ALU_FLAG_WE) begin
            sticky <= ALU_FLAGS;
        end else if (RETIRE.valid && RETIRE.flag_update_op) begin
            sticky <= RETIRE.update_flags;
        end else if (RETIRE.valid && RETIRE.may_except) begin
            sticky <= sticky | RETIRE.flags;
        end else if (wr_psw) begin
            sticky <= PWDATA[`PSW_INV_BIT:`PSW_INX_BIT];
        end
    end
    // own block: an alu write in the same cycle must not hide it
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            any_exc <= 1'b0;
        end else if (RETIRE.valid && RETIRE.may_except && !RETIRE.flag_update_op) begin
            any_exc <= |RETIRE.flags;
        end
    end
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rnd <= 2'h0;
        end else if (wr_rnd) begin
            rnd <= PWDATA[`PSW_RND_LSB +: 2];
        end else if (RETIRE.valid && RETIRE.flag_update_op) begin
            rnd <= RETIRE.rounding_select;
        end
    end
    assign PSW_FLAGS = {any_exc, sticky};
    assign ROUNDING_SELECT = rnd;
    // ************************************************************
    // trap enables, capture and request
    // ************************************************************
    logic [4:0] trap_en;
    logic valid;
    logic [4:0] cap_flags;
    logic [1:0] cap_rnd;
    logic [31:0] cap_pc;
    logic [8:0] cap_opc;
    logic [3:0] cap_dreg;
    logic [31:0] cap_src [3];
    logic [31:0] src_in [3];
    logic hit;
    logic clear;
    // capture only at retirement, so the result path is never disturbed
    assign hit = RETIRE.valid && !valid
        && |(RETIRE.flags & trap_en);
    assign clear = wr_ctrl && PWDATA[`CTL_CLEAR_BIT];
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            trap_en <= 5'h00;
        end else if (wr_ctrl) begin
            trap_en <= PWDATA[`CTL_EN_LSB +: 5];
        end
    end
    // set beats clear when both land together
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            valid <= 1'b0;
        end else if (hit) begin
            valid <= 1'b1;
        end else if (clear) begin
            valid <= 1'b0;
        end
    end
    // result deliberately not captured
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cap_flags <= 5'h00;
            cap_rnd <= 2'h0;
            cap_pc <= `RESET_WORD;
            cap_opc <= 9'h000;
            cap_dreg <= 4'h0;
        end else if (hit) begin
            cap_flags <= RETIRE.flags;
            cap_rnd <= RETIRE.rounding_select;
            cap_pc <= RETIRE.pc;
            cap_opc <= RETIRE.opcode;
            cap_dreg <= RETIRE.dreg;
        end
    end
    // one capture word per source operand
    assign src_in[0] = RETIRE.src1;
    assign src_in[1] = RETIRE.src2;
    assign src_in[2] = RETIRE.src3;
    for (genvar k = 0; k < 3; k++) begin : g_src
        always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
                cap_src[k] <= `RESET_WORD;
            end else if (hit) begin
                cap_src[k] <= src_in[k];
            end
        end
    end
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TRAP_REQ <= 1'b0;
        end else begin
            TRAP_REQ <= hit;
        end
    end
    assign TRAP_CLASS = `TRAP_CLASS;
    assign TRAP_IDENT = `TRAP_IDENT;
    // ************************************************************
    // apb slave, zero wait states
    // ************************************************************
    always_comb begin
        enables = `RESET_WORD;
        enables[`CTL_EN_LSB +: 5] = trap_en;
        enables[`CTL_CAP_FLAG_LSB +: 5] = cap_flags;
        enables[`CTL_CAP_RND_LSB +: 2] = cap_rnd;
        enables[`CTL_VALID_BIT] = valid;
    end
    logic [31:0] next_prdata;
    // unmapped words read as zero, clear bit always reads zero
    always_comb begin
        case (PADDR)
            `OFS_TRAP_CTRL: next_prdata = enables;
            `OFS_TRAP_PC: next_prdata = cap_pc;
            `OFS_TRAP_OPC: next_prdata = {12'h000, cap_dreg, 7'h00, cap_opc};
            `OFS_TRAP_SRC1: next_prdata = cap_src[0];
            `OFS_TRAP_SRC2: next_prdata = cap_src[1];
            `OFS_TRAP_SRC3: next_prdata = cap_src[2];
            `OFS_PSW_FLAGS: next_prdata = {PSW_FLAGS, 26'h0000000};
            `OFS_FLAG_UPDATE: next_prdata = {6'h00, rnd, 24'h000000};
            default: next_prdata = `RESET_WORD;
        endcase
    end
    // latched in the setup cycle, so it stands through the access phase
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PRDATA <= `RESET_WORD;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= next_prdata;
        end
    end
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
endmodule

// ===== sim/fpu_exc_asserts.sv
// concurrent checks on the ports of the fpu exception unit
// assumes a bind from the testbench top file, one clock domain
`timescale 1ns/1ps
`include "fpu_exc_defines.svh"
module fpu_exc_asserts
    import fpu_exc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire fpu_classify_s CLASSIFY,
    input wire logic [31:0] RESULT,
    input wire logic [4:0] OP_FLAGS,
    input wire fpu_retire_s RETIRE,
    input wire logic ALU_FLAG_WE,
    input wire logic [4:0] ALU_FLAGS,
    input wire logic [5:0] PSW_FLAGS,
    input wire logic TRAP_REQ,
    input wire logic [2:0] TRAP_CLASS,
    input wire logic [7:0] TRAP_IDENT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    // ****
    // properties
    // ****
    trap_code_a: assert property (TRAP_CLASS == `TRAP_CLASS && TRAP_IDENT == `TRAP_IDENT)
        else $error("trap class or ident wrong");
    trap_pulse_a: assert property (TRAP_REQ |=> !TRAP_REQ)
        else $error("trap request longer than one cycle");
    // the pulse comes one edge after the retire strobe; the check also accepts two edges
    trap_cause_a: assert property (TRAP_REQ |-> $past(RETIRE.valid) || $past(RETIRE.valid, 2))
        else $error("trap request without a completed instruction");
    one_cause_a: assert property ($onehot0(OP_FLAGS[4:1]))
        else $error("more than one exclusive flag");
    inexact_forced_a: assert property ((OP_FLAGS[3] || OP_FLAGS[1]) |-> OP_FLAGS[0])
        else $error("inexact missing on overflow or underflow");
    inexact_block_a: assert property ((OP_FLAGS[4] || OP_FLAGS[2]) |-> !OP_FLAGS[0])
        else $error("inexact with invalid or divide by zero");
    nan_result_a: assert property ((CLASSIFY.any_nan && CLASSIFY.op[6:1] != 6'h00) |=>
        RESULT == `QNAN_OPERAND && OP_FLAGS[4] == $past(CLASSIFY.snan))
        else $error("nan operand result wrong");
    flags_sticky_a: assert property ((!ALU_FLAG_WE && !(RETIRE.valid && RETIRE.flag_update_op)
        && !(PSEL && PENABLE && PWRITE)) |=>
        (PSW_FLAGS[4:0] & $past(PSW_FLAGS[4:0])) == $past(PSW_FLAGS[4:0]))
        else $error("sticky flag lost");
    alu_write_a: assert property (ALU_FLAG_WE |=> PSW_FLAGS[4:0] == $past(ALU_FLAGS))
        else $error("alu flag write not taken");
    any_update_a: assert property ((RETIRE.valid && RETIRE.may_except && !RETIRE.flag_update_op)
        |=> PSW_FLAGS[5] == (|$past(RETIRE.flags)))
        else $error("any-exception flag wrong");
    any_hold_a: assert property ((RETIRE.valid && RETIRE.flag_update_op) |=> $stable(PSW_FLAGS[5]))
        else $error("flag update touched any-exception");
    cover property (TRAP_REQ);
    cover property (ALU_FLAG_WE);
    cover property (CLASSIFY.any_nan ##1 RESULT == `QNAN_OPERAND);
endmodule

// ===== sim/core_model.sv
// core pipeline side: retires instructions one at a time, counts trap pulses
// assumes issue is called just after a rising edge
`timescale 1ns/1ps
module core_model
    import fpu_exc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic trap,
    output fpu_retire_s retire,
    output logic [7:0] traps
);
    initial retire = '0;
    // strobe stands for exactly one cycle so no instruction retires twice
    task automatic issue(input fpu_retire_s w);
        @(posedge clk);
        retire <= w;
        @(posedge clk);
        retire <= '0;
    endtask
    // each high cycle is a separate trap entry
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            traps <= 8'h00;
        end else if (trap) begin
            traps <= traps + 8'h01;
        end
    end
endmodule

// ===== sim/testbench.sv
// self-checking bench: apb tasks, special results, flags and trap capture
// assumes the design, package and checker compiled before it
`timescale 1ns/1ps
`include "fpu_exc_defines.svh"
module testbench;
    import fpu_exc_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    fpu_classify_s CLASSIFY = '0;
    logic ALU_FLAG_WE = 1'b0;
    logic [4:0] ALU_FLAGS = 5'h00;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] RESULT, PRDATA, q;
    logic [4:0] OP_FLAGS;
    logic [5:0] PSW_FLAGS;
    logic [1:0] ROUNDING_SELECT;
    logic TRAP_REQ, PREADY, PSLVERR;
    logic [2:0] TRAP_CLASS;
    logic [7:0] TRAP_IDENT, traps;
    fpu_retire_s RETIRE;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] ovf_tab [8] = '{`POS_INF, `NEG_INF, `POS_INF, 32'hFF7FFFFF,
        32'h7F7FFFFF, `NEG_INF, 32'h7F7FFFFF, 32'hFF7FFFFF};
    logic [11:0] cap_a [5] = '{`OFS_TRAP_PC, `OFS_TRAP_OPC, `OFS_TRAP_SRC1, `OFS_TRAP_SRC2,
        `OFS_TRAP_SRC3};
    logic [31:0] cap_e [5] = '{32'h00001000, 32'h000701A3, 32'hFFFFEFFF, 32'h5A5A4A5A,
        32'h00001010};
    always #4 CLK_SYS = ~CLK_SYS;
    fpu_exception_trap_logic i_dut (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .CLASSIFY(CLASSIFY),
        .RESULT(RESULT),
        .OP_FLAGS(OP_FLAGS),
        .RETIRE(RETIRE),
        .ALU_FLAG_WE(ALU_FLAG_WE),
        .ALU_FLAGS(ALU_FLAGS),
        .PSW_FLAGS(PSW_FLAGS),
        .ROUNDING_SELECT(ROUNDING_SELECT),
        .TRAP_REQ(TRAP_REQ),
        .TRAP_CLASS(TRAP_CLASS),
        .TRAP_IDENT(TRAP_IDENT),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR)
    );
    core_model i_core (.clk(CLK_SYS), .rst(RST), .trap(TRAP_REQ), .retire(RETIRE), .traps(traps));
    // ****
    // tasks
    // ****
    task conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        r = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic sp(input logic [7:0] op, input logic [17:0] b, input logic [31:0] r,
        input logic [31:0] er, input logic [4:0] ef, input logic cr);
        @(posedge CLK_SYS);
        CLASSIFY <= fpu_classify_s'({op, b, r});
        repeat (2) @(posedge CLK_SYS);
        if (cr) chk("result", er, RESULT);
        chk("flags", {27'h0, ef}, {27'h0, OP_FLAGS});
    endtask
    task automatic ret(input logic fu, input logic [4:0] fl, input logic [4:0] uf,
        input logic [31:0] pc);
        fpu_retire_s w;
        w = '{valid: 1'b1, flag_update_op: fu, may_except: 1'b1, flags: fl, update_flags: uf,
            rounding_select: 2'h2, pc: pc, opcode: 9'h1A3, dreg: 4'h7, src1: ~pc,
            src2: pc ^ 32'h5A5A5A5A, src3: pc + 32'h10};
        i_core.issue(w);
        repeat (3) @(posedge CLK_SYS);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        apb(1'b0, `OFS_TRAP_CTRL, '0, q);
        chk("ctrl reset", 32'h0, q);
        chk("psw reset", 32'h0, {26'h0, PSW_FLAGS});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `OFS_FLAG_UPDATE, {6'h0, i[2:1], 24'h0}, q);
            sp(OP_MUL, {17'h0000A, i[0]}, '0, ovf_tab[i], 5'h09, 1'b1);
            chk("rounding", {30'h0, i[2:1]}, {30'h0, ROUNDING_SELECT});
        end
        apb(1'b1, `OFS_FLAG_UPDATE, '0, q);
        $display("test overflow done");
        sp(OP_ADD, 18'h10000, '0, `QNAN_OPERAND, 5'h00, 1'b1);
        sp(OP_ADD, 18'h18000, '0, `QNAN_OPERAND, 5'h10, 1'b1);
        sp(OP_ADD, 18'h06100, '0, `QNAN_INF_CANCEL, 5'h10, 1'b1);
        sp(OP_SUB, 18'h06000, '0, `QNAN_INF_CANCEL, 5'h10, 1'b1);
        sp(OP_MADD, 18'h010C0, '0, `QNAN_INF_CANCEL, 5'h10, 1'b1);
        sp(OP_MSUB, 18'h01040, '0, `QNAN_INF_CANCEL, 5'h10, 1'b1);
        sp(OP_MUL, 18'h02800, '0, `QNAN_ZERO_INF, 5'h10, 1'b1);
        sp(OP_MADD, 18'h02800, '0, `QNAN_ZERO_INF, 5'h10, 1'b1);
        sp(OP_OTHER, 18'h20200, '0, `QNAN_SEED_NEG, 5'h10, 1'b1);
        sp(OP_OTHER, 18'h20A00, '0, `NEG_INF, 5'h00, 1'b1);
        sp(OP_DIV, 18'h00C00, '0, `QNAN_DIV_INV, 5'h10, 1'b1);
        sp(OP_DIV, 18'h06000, '0, `QNAN_DIV_INV, 5'h10, 1'b1);
        sp(OP_DIV, 18'h00601, '0, `NEG_INF, 5'h04, 1'b1);
        sp(OP_DIV, 18'h04400, '0, `POS_INF, 5'h00, 1'b1);
        sp(OP_MUL, 18'h0000C, '0, '0, 5'h03, 1'b1);
        sp(OP_ADD, 18'h00004, 32'h3F800001, 32'h3F800001, 5'h01, 1'b1);
        sp(OP_OTHER, 18'h00002, '0, '0, 5'h10, 1'b0);
        $display("test specials done");
        ret(1'b0, 5'h01, 5'h00, 32'h100);
        chk("psw", 32'h21, {26'h0, PSW_FLAGS});
        ret(1'b1, 5'h00, 5'h10, 32'h104);
        chk("psw", 32'h30, {26'h0, PSW_FLAGS});
        ret(1'b0, 5'h00, 5'h00, 32'h108);
        chk("psw", 32'h10, {26'h0, PSW_FLAGS});
        ALU_FLAG_WE <= 1'b1;
        ALU_FLAGS <= 5'h0A;
        @(posedge CLK_SYS);
        ALU_FLAG_WE <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        chk("psw", 32'h0A, {26'h0, PSW_FLAGS});
        $display("test flags done");
        apb(1'b1, `OFS_TRAP_CTRL, 32'h00200000, q);
        ret(1'b0, 5'h01, 5'h00, 32'h900);
        chk("traps", 32'h0, {24'h0, traps});
        ret(1'b0, 5'h09, 5'h00, 32'h1000);
        chk("traps", 32'h1, {24'h0, traps});
        chk("ident", 32'h404, {21'h0, TRAP_CLASS, TRAP_IDENT});
        apb(1'b0, `OFS_TRAP_CTRL, '0, q);
        chk("ctrl", 32'h24200201, q);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, cap_a[i], '0, q);
            chk("capture", cap_e[i], q);
        end
        ret(1'b0, 5'h08, 5'h00, 32'h2000);
        chk("traps", 32'h1, {24'h0, traps});
        apb(1'b0, `OFS_TRAP_PC, '0, q);
        chk("pc held", 32'h1000, q);
        apb(1'b1, `OFS_TRAP_CTRL, 32'h00200000, q);
        apb(1'b0, `OFS_TRAP_CTRL, '0, q);
        chk("ctrl", 32'h24200201, q);
        apb(1'b1, `OFS_TRAP_CTRL, 32'h00200002, q);
        apb(1'b0, `OFS_TRAP_CTRL, '0, q);
        chk("cleared", 32'h0, q & 32'h3);
        ret(1'b0, 5'h08, 5'h00, 32'h3000);
        chk("traps", 32'h2, {24'h0, traps});
        apb(1'b0, `OFS_TRAP_PC, '0, q);
        chk("pc new", 32'h3000, q);
        apb(1'b1, 12'h040, 32'hFFFFFFFF, q);
        apb(1'b0, 12'h040, '0, q);
        chk("unmapped", 32'h0, q);
        chk("slverr", 32'h0, {31'h0, PSLVERR});
        apb(1'b1, `OFS_PSW_FLAGS, 32'h7C000000, q);
        apb(1'b0, `OFS_PSW_FLAGS, '0, q);
        chk("psw word", 32'hFC000000, q);
        $display("test trap done");
        conclude();
    end
endmodule
bind fpu_exception_trap_logic fpu_exc_asserts i_chk (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .CLASSIFY(CLASSIFY),
    .RESULT(RESULT),
    .OP_FLAGS(OP_FLAGS),
    .RETIRE(RETIRE),
    .ALU_FLAG_WE(ALU_FLAG_WE),
    .ALU_FLAGS(ALU_FLAGS),
    .PSW_FLAGS(PSW_FLAGS),
    .TRAP_REQ(TRAP_REQ),
    .TRAP_CLASS(TRAP_CLASS),
    .TRAP_IDENT(TRAP_IDENT),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE)
);
